// [rtl/ispseq_map.svh]
/*
 * register offsets, field positions, reset values and timing counts
 * for the flash command sequencer; assumes a 50 MHz system clock.
 */
`ifndef ISPSEQ_MAP_SVH
`define ISPSEQ_MAP_SVH

// ----------------------------------------------------------------------
// register indices, compared directly with avs_address
// ----------------------------------------------------------------------
`define ISPSEQ_IDX_TRIGGER 8'hA4
`define ISPSEQ_IDX_DATA 8'hAE
`define ISPSEQ_IDX_CMD 8'hAF
`define ISPSEQ_IDX_ADDR_H 8'hA7
`define ISPSEQ_IDX_ADDR_L 8'hA6
`define ISPSEQ_IDX_CHIPCTL 8'h9F
`define ISPSEQ_IDX_GUARD 8'hC7
`define ISPSEQ_IDX_STATUS 8'hC8
`define ISPSEQ_ADDR_W 10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ISPSEQ_GO_BIT 0
`define ISPSEQ_EN_BIT 0
`define ISPSEQ_BS_BIT 1
`define ISPSEQ_LDU_BIT 5
`define ISPSEQ_FAULT_BIT 6

// ----------------------------------------------------------------------
// command encodings and unlock keys
// ----------------------------------------------------------------------
`define ISPSEQ_OP_ERASE 4'h2
`define ISPSEQ_OP_PROG 4'h1
`define ISPSEQ_OP_READ 4'h0
`define ISPSEQ_DST_APP 2'h0
`define ISPSEQ_DST_LDR 2'h1
`define ISPSEQ_DST_CFG 2'h3
`define ISPSEQ_KEY1 8'hAA
`define ISPSEQ_KEY2 8'h55
`define ISPSEQ_RST_BYTE 8'h00

// ----------------------------------------------------------------------
// timing: operation times in microseconds
// ----------------------------------------------------------------------
`define ISPSEQ_CLK_MHZ 50
`define ISPSEQ_T_ERASE_US 5000
`define ISPSEQ_T_PROG_US 40
`define ISPSEQ_T_READ_US 1
`define ISPSEQ_CYC(us) ((us) * `ISPSEQ_CLK_MHZ)

`endif

// [rtl/ispseq_pkg.sv]
/*
 * types shared by the flash command sequencer;
 * assumes the map header is compiled alongside.
 */
package ispseq_pkg;

	// sequencer states, one bit changing from idle to run and from run to done
	typedef enum logic [1:0] {
		ISPSEQ_IDLE = 2'b00,
		ISPSEQ_RUN = 2'b01,
		ISPSEQ_DONE = 2'b11
	} ispseq_state_t;

	// flash array request bundle
	typedef struct packed {
		logic [17:0] addr;
		logic [7:0] wdata;
		logic oe_ctl;
		logic ce_ctl;
		logic [3:0] op;
		logic active;
	} ispseq_flash_req_t;

endpackage : ispseq_pkg

// [rtl/ispseq_top.sv]
/*
 * flash command sequencer with Avalon-MM register slave.
 * assumes a flash array that accepts a request while active is high
 * and returns read data in flash_rdata; cpu context flags are levels
 * from the cpu core on sys_clk.
 */
// Function
// RL1: eight-bit data register holds program byte and read result.
// RL2: software loads data before program, reads result after completion.
// RL3: writing one to go bit starts the selected operation.
// RL4: cpu program counter stalls during the operation, resumes after.
// RL5: go bit clears itself at completion and always reads zero.
// RL6: trigger register writes need the timed-access unlock.
// RL7: command code selects erase, program, read; oe/ce select standby.
// RL8: two upper address bits select application, loader or config area.
// RL9: config erase clears all config bytes, high byte zero required.
// RL10: page erase acts on the 256-byte page of the high byte.
// RL11: with access enable cleared, go writes are ignored.
// RL12: internal oscillator times work, stops when enable off on external.
// RL13: access enable writes need the timed-access unlock.
// RL14: running from external memory refuses operation and sets fault.
// RL15: config access allowed only while code runs from loader area.
// RL16: new config values apply after reset; boot select not after soft.
// RL17: security lock does not block operations through this sequencer.
// RL18: application or loader code may read its own area.
// RL19: software clears global interrupt enable during operations.
// RL20: software should rewrite config bytes as final update step.
// RL21: illegal accesses set the fault flag.
// RL22: loader area read-only from application code unless update enabled.
// RL23: fault flag stays set until software clears it.
// RL24: sixteen-bit address plus two command bits drive the flash array.
// RL25: cpu hold spans the operation and drops with the go bit.
// RL26: go with standby encoding completes without changing anything.
`timescale 1ns/1ps
`include "ispseq_map.svh"

module ispseq_top
	import ispseq_pkg::*;
#(
	parameter int T_ERASE_CYC = `ISPSEQ_CYC(`ISPSEQ_T_ERASE_US),
	parameter int T_PROG_CYC = `ISPSEQ_CYC(`ISPSEQ_T_PROG_US),
	parameter int T_READ_CYC = `ISPSEQ_CYC(`ISPSEQ_T_READ_US),
	parameter int CNT_W = 20
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [`ISPSEQ_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic run_from_loader,
	input wire logic run_external,
	input wire logic ext_clk_selected,
	input wire logic soft_reset_event,
	input wire logic [7:0] flash_rdata,
	output ispseq_flash_req_t flash_req_r,
	output logic cpu_hold_r,
	output logic rc_osc_en_r,
	output logic cfg_apply_r,
	output logic boot_sel_apply_r
);

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	ispseq_state_t state_r;
	logic [7:0] data_r;
	logic [7:0] cmd_r;
	logic [7:0] addr_h_r;
	logic [7:0] addr_l_r;
	logic en_r;
	logic ldu_r;
	logic bs_r;
	logic fault_r;
	logic [1:0] unlock_r;
	logic go_r;
	logic [CNT_W-1:0] cnt_r;
	logic cfg_dirty_r;
	logic bs_dirty_r;
	logic ack_r;

	// ------------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------------
	logic [7:0] wbyte;
	logic wr_stb;
	logic rd_stb;
	logic unlocked;
	logic go_req;
	logic [3:0] op;
	logic [1:0] dst;
	logic standby;
	logic modify;
	logic illegal;
	logic start_ok;
	logic fault_set;
	logic [CNT_W-1:0] dur;

	assign wbyte = avs_writedata[7:0];
	// one wait cycle per access: write lands at the edge where
	// waitrequest is sampled low; read data is captured one edge earlier
	assign wr_stb = avs_write & avs_byteenable[0] & ack_r;
	assign rd_stb = avs_read & ~ack_r;
	assign unlocked = (unlock_r == 2'd2);
	assign op = cmd_r[3:0];
	assign dst = cmd_r[7:6];
	assign standby = cmd_r[5] & cmd_r[4]; // [RL7]
	assign modify = (op == `ISPSEQ_OP_ERASE) | (op == `ISPSEQ_OP_PROG);

	// go request: unlocked trigger write with bit 0 while enabled
	assign go_req = wr_stb && avs_address == `ISPSEQ_IDX_TRIGGER && unlocked
		&& wbyte[`ISPSEQ_GO_BIT] && en_r && state_r == ISPSEQ_IDLE; // [RL3] [RL6] [RL11]

	// legality check for the selected area
	always_comb
	begin
		illegal = 1'b0;
		if (run_external) // [RL14]
			illegal = 1'b1;
		else if (!standby)
		begin
			case (dst)
				`ISPSEQ_DST_APP: illegal = modify & ~run_from_loader; // [RL18] [RL21]
				`ISPSEQ_DST_LDR: illegal = modify & (run_from_loader | ~ldu_r); // [RL22]
				`ISPSEQ_DST_CFG: illegal = ~run_from_loader // [RL15] [RL17]
					| (op == `ISPSEQ_OP_ERASE && addr_h_r != 8'h00) // [RL9]
					| (op != `ISPSEQ_OP_ERASE && addr_h_r != 8'h00)
					| (op != `ISPSEQ_OP_ERASE && addr_l_r > 8'h03);
				default: illegal = 1'b1; // unused area code 2'h2
			endcase
			if (op != `ISPSEQ_OP_ERASE && op != `ISPSEQ_OP_PROG
				&& op != `ISPSEQ_OP_READ)
				illegal = 1'b1;
		end
	end

	assign start_ok = go_req & ~illegal;
	assign fault_set = go_req & illegal; // [RL21]

	// duration by operation
	always_comb
	begin
		dur = CNT_W'(T_READ_CYC);
		if (standby)
			dur = CNT_W'(1); // [RL26]
		else if (op == `ISPSEQ_OP_ERASE)
			dur = CNT_W'(T_ERASE_CYC);
		else if (op == `ISPSEQ_OP_PROG)
			dur = CNT_W'(T_PROG_CYC);
	end

	// ------------------------------------------------------------------
	// bus handshake
	// ------------------------------------------------------------------
	// waitrequest high until the registered ack cycle
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			ack_r <= 1'b0;
		else
			ack_r <= (avs_read | avs_write) & ~ack_r;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= ~((avs_read | avs_write) & ~ack_r);
	end

	// read mux, registered
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			avs_readdata <= 32'h0000_0000;
		else if (rd_stb)
		begin
			case (avs_address)
				`ISPSEQ_IDX_TRIGGER: avs_readdata <= 32'h0000_0000; // [RL5]
				`ISPSEQ_IDX_DATA: avs_readdata <= {24'h00_0000, data_r};
				`ISPSEQ_IDX_CMD: avs_readdata <= {24'h00_0000, cmd_r};
				`ISPSEQ_IDX_ADDR_H: avs_readdata <= {24'h00_0000, addr_h_r};
				`ISPSEQ_IDX_ADDR_L: avs_readdata <= {24'h00_0000, addr_l_r};
				`ISPSEQ_IDX_CHIPCTL: avs_readdata <= {25'h000_0000, fault_r,
					ldu_r, 3'h0, bs_r, en_r};
				`ISPSEQ_IDX_STATUS: avs_readdata <= {30'h0000_0000,
					state_r != ISPSEQ_IDLE, go_r};
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// timed-access unlock
	// ------------------------------------------------------------------
	// two key writes open one protected write, any other write closes it
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			unlock_r <= 2'd0;
		else if (wr_stb)
		begin
			if (avs_address == `ISPSEQ_IDX_GUARD && wbyte == `ISPSEQ_KEY1)
				unlock_r <= 2'd1;
			else if (avs_address == `ISPSEQ_IDX_GUARD && unlock_r == 2'd1
				&& wbyte == `ISPSEQ_KEY2)
				unlock_r <= 2'd2;
			else
				unlock_r <= 2'd0; // [RL6] [RL13]
		end
	end

	// ------------------------------------------------------------------
	// plain registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cmd_r <= `ISPSEQ_RST_BYTE;
			addr_h_r <= `ISPSEQ_RST_BYTE;
			addr_l_r <= `ISPSEQ_RST_BYTE;
		end
		else if (wr_stb && state_r == ISPSEQ_IDLE)
		begin
			if (avs_address == `ISPSEQ_IDX_CMD)
				cmd_r <= wbyte;
			if (avs_address == `ISPSEQ_IDX_ADDR_H)
				addr_h_r <= wbyte;
			if (avs_address == `ISPSEQ_IDX_ADDR_L)
				addr_l_r <= wbyte;
		end
	end

	// data byte: software write, or read result at completion
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			data_r <= `ISPSEQ_RST_BYTE;
		else if (state_r == ISPSEQ_DONE && !standby
			&& op == `ISPSEQ_OP_READ)
			data_r <= flash_rdata; // [RL1]
		else if (wr_stb && avs_address == `ISPSEQ_IDX_DATA
			&& state_r == ISPSEQ_IDLE)
			data_r <= wbyte; // [RL1]
	end

	// chip control: protected enable, boot select and loader update
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			en_r <= 1'b0;
			ldu_r <= 1'b0;
			bs_r <= 1'b0;
		end
		else if (wr_stb && avs_address == `ISPSEQ_IDX_CHIPCTL && unlocked)
		begin
			en_r <= wbyte[`ISPSEQ_EN_BIT]; // [RL13]
			ldu_r <= wbyte[`ISPSEQ_LDU_BIT];
			bs_r <= wbyte[`ISPSEQ_BS_BIT];
		end
	end

	// fault flag: set wins over software clear
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			fault_r <= 1'b0;
		else if (fault_set)
			fault_r <= 1'b1; // [RL21] [RL14]
		else if (wr_stb && avs_address == `ISPSEQ_IDX_CHIPCTL && unlocked
			&& !wbyte[`ISPSEQ_FAULT_BIT])
			fault_r <= 1'b0; // [RL23]
	end

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= ISPSEQ_IDLE;
			cnt_r <= '0;
			go_r <= 1'b0;
			cpu_hold_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				ISPSEQ_IDLE:
					if (start_ok)
					begin
						state_r <= ISPSEQ_RUN;
						cnt_r <= dur;
						go_r <= 1'b1;
						cpu_hold_r <= 1'b1; // [RL4] [RL25]
					end
				ISPSEQ_RUN:
					if (cnt_r <= CNT_W'(1))
						state_r <= ISPSEQ_DONE;
					else
						cnt_r <= cnt_r - CNT_W'(1);
				ISPSEQ_DONE:
				begin
					state_r <= ISPSEQ_IDLE;
					go_r <= 1'b0; // [RL5]
					cpu_hold_r <= 1'b0; // [RL4] [RL25]
				end
				default: state_r <= ISPSEQ_IDLE;
			endcase
		end
	end

	// flash request: active for real operations only
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			flash_req_r <= '{addr: 18'h0_0000, wdata: 8'h00, oe_ctl: 1'b1,
				ce_ctl: 1'b1, op: 4'h0, active: 1'b0};
		else
		begin
			flash_req_r.addr <= {dst, addr_h_r, addr_l_r}; // [RL24] [RL8] [RL10]
			flash_req_r.wdata <= data_r;
			flash_req_r.oe_ctl <= cmd_r[5]; // [RL7]
			flash_req_r.ce_ctl <= cmd_r[4];
			flash_req_r.op <= op;
			flash_req_r.active <= (state_r != ISPSEQ_IDLE || start_ok)
				&& !standby; // [RL26]
		end
	end

	// rc oscillator runs while enabled or the internal clock is in use
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			rc_osc_en_r <= 1'b1;
		else
			rc_osc_en_r <= en_r | ~ext_clk_selected; // [RL12]
	end

	// config apply: pending after config erase or program, applied on next soft reset event
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_dirty_r <= 1'b0;
			bs_dirty_r <= 1'b0;
			cfg_apply_r <= 1'b0;
			boot_sel_apply_r <= 1'b0;
		end
		else
		begin
			cfg_apply_r <= 1'b0;
			boot_sel_apply_r <= 1'b0;
			if (state_r == ISPSEQ_DONE && dst == `ISPSEQ_DST_CFG && modify
				&& !standby)
			begin
				cfg_dirty_r <= 1'b1;
				bs_dirty_r <= 1'b1;
			end
			else if (soft_reset_event && cfg_dirty_r)
			begin
				cfg_dirty_r <= 1'b0;
				cfg_apply_r <= 1'b1; // [RL16]
			end
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	sequence s_start;
		start_ok;
	endsequence

	sequence s_finish;
		state_r == ISPSEQ_DONE ##1 !go_r && !cpu_hold_r;
	endsequence

	AST_HOLD_START: assert property (@(posedge sys_clk) disable iff (rst)
		s_start |=> cpu_hold_r && go_r) // [RL4]
		else $error("hold not raised at start");

	AST_HOLD_GO: assert property (@(posedge sys_clk) disable iff (rst)
		cpu_hold_r == go_r) // [RL25]
		else $error("hold and go differ");

	AST_DONE_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
		state_r == ISPSEQ_DONE |-> s_finish) // [RL5]
		else $error("go not cleared at done");

	AST_NO_EN: assert property (@(posedge sys_clk) disable iff (rst)
		!en_r && state_r == ISPSEQ_IDLE |=> state_r == ISPSEQ_IDLE) // [RL11]
		else $error("started while disabled");

	AST_EXT_FAULT: assert property (@(posedge sys_clk) disable iff (rst)
		go_req && run_external |=> fault_r && state_r == ISPSEQ_IDLE) // [RL14]
		else $error("external run not refused");

	AST_FAULT_STICKY: assert property (@(posedge sys_clk) disable iff (rst)
		fault_r && !(wr_stb && avs_address == `ISPSEQ_IDX_CHIPCTL)
		|=> fault_r) // [RL23]
		else $error("fault cleared by hardware");

	AST_LOCK_TRG: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(go_r) |-> $past(unlock_r) == 2'd2) // [RL6]
		else $error("go without unlock");

	AST_STANDBY: assert property (@(posedge sys_clk) disable iff (rst)
		state_r != ISPSEQ_IDLE && standby |-> !flash_req_r.active
		&& $stable(data_r)) // [RL26]
		else $error("standby touched flash");

	AST_TRG_READ0: assert property (@(posedge sys_clk) disable iff (rst)
		rd_stb && avs_address == `ISPSEQ_IDX_TRIGGER |=> avs_readdata == 0) // [RL5]
		else $error("trigger read nonzero");

endmodule : ispseq_top

// [dv/ispseq_flash_model.sv]
/*
 * behavioural flash array: page erase, config erase, program, read.
 * assumes the sequencer request bundle, registered on sys_clk.
 */
`timescale 1ns/1ps
module ispseq_flash_model
	import ispseq_pkg::*;
(
	input wire logic sys_clk,
	input wire ispseq_flash_req_t flash_req_r,
	output logic [7:0] flash_rdata
);
	logic [7:0] mem [logic [17:0]];
	logic act_d_r = 1'b0;
	logic [17:0] a;

	initial flash_rdata = 8'h3c;

	// act once per request; cells never written read as erased
	always @(posedge sys_clk)
	begin
		a = flash_req_r.addr;
		act_d_r <= flash_req_r.active;
		if (flash_req_r.active && !act_d_r && !flash_req_r.ce_ctl)
		begin
			if (flash_req_r.op == 4'h2)
			begin
				foreach (mem[k])
				begin
					if (k[17:8] == a[17:8] ||
						(a[17:16] == 2'h3 && k[17:16] == 2'h3))
						mem[k] = 8'hff;
				end
			end
			else if (flash_req_r.op == 4'h1) // program only clears bits
				mem[a] = (mem.exists(a) ? mem[a] : 8'hff) &
					flash_req_r.wdata;
			else if (flash_req_r.op == 4'h0)
				flash_rdata <= mem.exists(a) ? mem[a] : 8'hff;
		end
		else if (!flash_req_r.active && !act_d_r)
			flash_rdata <= ~flash_rdata; // released: inverted every cycle, so the old byte returns on alternate cycles
	end
endmodule : ispseq_flash_model

// [dv/tb.sv]
/*
 * self-checking bench for the flash command sequencer.
 * assumes the flash model in dv/ and the map header on the include path.
 */
`timescale 1ns/1ps
`include "ispseq_map.svh"
module tb
	import ispseq_pkg::*;
;
	localparam logic [7:0] a_cmd = `ISPSEQ_IDX_CMD;
	localparam logic [7:0] a_dat = `ISPSEQ_IDX_DATA;
	localparam logic [7:0] a_trg = `ISPSEQ_IDX_TRIGGER;
	localparam logic [7:0] a_ctl = `ISPSEQ_IDX_CHIPCTL;
	localparam logic [7:0] a_sts = `ISPSEQ_IDX_STATUS;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [9:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = 4'h1;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic run_from_loader = 1'b0;
	logic run_external = 1'b0;
	logic ext_clk_selected = 1'b0;
	logic soft_reset_event = 1'b0;
	logic [7:0] flash_rdata;
	ispseq_flash_req_t flash_req_r;
	logic cpu_hold_r;
	logic rc_osc_en_r;
	logic cfg_apply_r;
	logic boot_sel_apply_r;
	logic seen;
	logic bs;
	logic [15:0] ad [3];
	logic [7:0] dv [3];
	int error_cnt = 0;
	int n_checks = 0;
	logic [31:0] exp_q [$];

	ispseq_top #(.T_ERASE_CYC(20), .T_PROG_CYC(8), .T_READ_CYC(4))
	ispseq_top_inst (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.run_from_loader(run_from_loader), .run_external(run_external),
		.ext_clk_selected(ext_clk_selected),
		.soft_reset_event(soft_reset_event), .flash_rdata(flash_rdata),
		.flash_req_r(flash_req_r), .cpu_hold_r(cpu_hold_r),
		.rc_osc_en_r(rc_osc_en_r), .cfg_apply_r(cfg_apply_r),
		.boot_sel_apply_r(boot_sel_apply_r));
	ispseq_flash_model ispseq_flash_model_inst (.sys_clk(sys_clk),
		.flash_req_r(flash_req_r), .flash_rdata(flash_rdata));

	// ----------------------------------------------------------------
	// report, compare and bus tasks
	// ----------------------------------------------------------------
	task results;
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// one avalon access, held until waitrequest is sampled low
	task bus(input logic r, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge sys_clk);
		avs_address <= {2'b00, a};
		avs_writedata <= {24'h00_0000, d};
		avs_read <= r;
		avs_write <= !r;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 100);
		if (n >= 100)
		begin
			error_cnt++;
			results();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b0, a, d);
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({24'h00_0000, e});
		bus(1'b1, a, 8'h00);
	endtask : rd

	// unlock, then protected write
	task prot(input logic [7:0] a, input logic [7:0] d);
		wr(`ISPSEQ_IDX_GUARD, `ISPSEQ_KEY1);
		wr(`ISPSEQ_IDX_GUARD, `ISPSEQ_KEY2);
		wr(a, d);
	endtask : prot

	// load regs, trigger; md 0 refused, 1 runs, 2 standby
	task go(input logic [7:0] c, input logic [15:0] ad_i,
		input logic [7:0] d, input int md);
		int n;
		wr(a_cmd, c);
		wr(`ISPSEQ_IDX_ADDR_H, ad_i[15:8]);
		wr(`ISPSEQ_IDX_ADDR_L, ad_i[7:0]);
		wr(a_dat, d); // data before trigger
		prot(a_trg, 8'h01);
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (cpu_hold_r !== 1'b1 && n < 4);
		if (md != 2) chk(32'(cpu_hold_r), 32'(md == 1));
		if (md == 1)
		begin
			@(posedge sys_clk);
			chk(32'(flash_req_r.addr), {14'h0000, c[7:6], ad_i});
			chk(32'({flash_req_r.oe_ctl, flash_req_r.ce_ctl, flash_req_r.op,
				flash_req_r.active}), {25'h000_0000, c[5:0], 1'b1});
			if (c[3:0] == 4'h1) chk(32'(flash_req_r.wdata), 32'(d));
			rd(a_trg, 8'h00);
		end
		n = 0;
		while (cpu_hold_r === 1'b1 && n < 60)
		begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 60)
		begin
			error_cnt++;
			results();
		end
		rd(a_sts, 8'h00);
	endtask : go

	// ----------------------------------------------------------------
	// read data checker fed by the expectation queue
	// ----------------------------------------------------------------
	always @(posedge sys_clk)
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
			chk(avs_readdata, exp_q.pop_front());

	// clock
	initial forever #10 sys_clk = ~sys_clk;

	// ----------------------------------------------------------------
	// main sequence; no interrupt source runs during operations
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h3d4e));
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rd(a_dat, 8'h00);
		rd(a_trg, 8'h00);
		wr(8'h10, 8'ha5);
		rd(8'h10, 8'h00);
		go(8'h21, 16'h0100, 8'h5a, 0);
		wr(a_ctl, 8'h01);
		go(8'h21, 16'h0100, 8'h5a, 0);
		prot(a_ctl, 8'h01);
		chk(32'(rc_osc_en_r), 32'h0000_0001);
		// application updates are run from the loader area
		run_from_loader <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			ad[i] = {8'(i + 1), 8'($urandom())};
			dv[i] = 8'($urandom());
			go(8'h22, {ad[i][15:8], 8'h00}, 8'h00, 1);
			go(8'h21, ad[i], dv[i], 1);
			go(8'h00, ad[i], ~dv[i], 1);
			rd(a_dat, dv[i]);
		end
		go(8'h30, ad[0], 8'h77, 2);
		rd(a_dat, 8'h77);
		go(8'h00, ad[0], 8'h00, 1);
		rd(a_dat, dv[0]);
		go(8'h22, {ad[2][15:8], 8'h00}, 8'h00, 1);
		go(8'h00, ad[2], 8'h00, 1);
		rd(a_dat, 8'hff);
		go(8'h00, ad[1], 8'h00, 1);
		rd(a_dat, dv[1]);
		run_from_loader <= 1'b0;
		go(8'h61, 16'h0010, 8'h11, 0);
		rd(a_ctl, 8'h41);
		go(8'h00, ad[0], 8'h00, 1);
		rd(a_ctl, 8'h41);
		prot(a_ctl, 8'h01);
		rd(a_ctl, 8'h01);
		for (int i = 0; i < 2; i++)
		begin
			run_external <= 1'(i);
			go((i == 0) ? 8'hc0 : 8'h00, 16'h0003, 8'h00, 0);
			rd(a_ctl, 8'h41);
			prot(a_ctl, 8'h01);
		end
		run_external <= 1'b0;
		prot(a_ctl, 8'h21);
		go(8'h62, 16'h0500, 8'h00, 1);
		go(8'h61, 16'h0510, dv[0], 1);
		go(8'h40, 16'h0510, 8'h00, 1);
		rd(a_dat, dv[0]);
		prot(a_ctl, 8'h01);
		// config rewrite as the last step of an update
		run_from_loader <= 1'b1;
		go(8'he2, 16'h0037, 8'h00, 1);
		go(8'he1, 16'h0003, dv[2], 1);
		go(8'hc0, 16'h0003, 8'h00, 1);
		rd(a_dat, dv[2]);
		soft_reset_event <= 1'b1;
		@(posedge sys_clk);
		soft_reset_event <= 1'b0;
		seen = 1'b0;
		bs = 1'b0;
		repeat (4)
		begin
			@(posedge sys_clk);
			seen = seen | cfg_apply_r;
			bs = bs | boot_sel_apply_r;
		end
		chk(32'(seen), 32'h0000_0001);
		chk(32'(bs), 32'h0000_0000);
		ext_clk_selected <= 1'b1;
		prot(a_ctl, 8'h00);
		repeat (2) @(posedge sys_clk);
		chk(32'(rc_osc_en_r), 32'h0000_0000);
		go(8'h00, ad[0], 8'h00, 0);
		results();
	end
endmodule : tb
